// >>> rtl/irq_pkg.sv
// Purpose: Shared constants and types for the extended interrupt controller.
// Assumes: One 40 MHz clock, byte-wide special-function register port.
// Notes: Source index order is the fixed natural order, lowest wins within a priority level.
//
// Notes on behaviour
// - Timer-1 overflow flag clears when core vectors.
// - Serial1 control: rx flag bit0, tx bit1.
// - Enable byte: pins 2-4, radio, key, watchdog, i2c.
// - Enable bit 7 shared by i2c slave, spi.
// - Priority byte mirrors enables; one means high.
// - Flag byte layout, bit 5 reserved, resets zero.
// - Pin-2 flag copies pin each clock, unwritable.
// - Compare-0 pin-3 flag cleared by writing 0x02 in compare mode, else copies pin.
// - Compare-1 pin-4 flag cleared by writing 0x04 in compare mode, else copies pin.
// - Radio flag cleared by writing 0x08 only.
// - Key flag cleared by writing 0x10 only.
// - I2C master flag cleared by 0x40, unsettable.
// - Shared slave/spi flag cleared by 0x80.
// - Compare channels may set pin-3/pin-4, radio and key flags.
// - Pin-6 source forced high when wake gate high.
// - Global enable bit off masks every request.
// - Two levels, high preempts low, natural tiebreak.
`default_nettype none

package irq_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] TIMER_CTRL_ADDR = 8'h88;
	localparam logic [7:0] EXT_FLAGS_ADDR = 8'h91;
	localparam logic [7:0] SERIAL0_ADDR = 8'h98;
	localparam logic [7:0] BASE_EN_ADDR = 8'ha8;
	localparam logic [7:0] BASE_PRI_ADDR = 8'hb8;
	localparam logic [7:0] SERIAL1_ADDR = 8'hc0;
	localparam logic [7:0] DEV_CTRL_ADDR = 8'hcf;
	localparam logic [7:0] EXT_EN_ADDR = 8'he8;
	localparam logic [7:0] EXT_PRI_ADDR = 8'hf8;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int RX_BIT = 0;
	localparam int TX_BIT = 1;
	localparam int T1_FLAG_BIT = 7;
	localparam int GLOBAL_EN_BIT = 7;
	localparam int SER0_EN_BIT = 4;
	localparam int T1_EN_BIT = 3;
	localparam int SER1_EN_BIT = 0;
	localparam int SER1_PRI_BIT = 1;
	localparam int RESERVED_FLAG_BIT = 5;
	localparam logic [1:0] CC_COMPARE_MODE = 2'h2;

	// ----------------------------------------
	// Sources in natural order
	// ----------------------------------------
	localparam int SRC_COUNT = 11;
	localparam int SRC_W = 4;
	localparam logic [SRC_W-1:0] SRC_TIMER1 = 4'h0;
	localparam logic [7:0] VEC_INTERVAL = 8'h08;
	localparam logic [7:0] VEC_BASE = 8'h03;
	localparam logic [7:0] NATURAL_PRIO [SRC_COUNT] = '{8'h04, 8'h05, 8'h07, 8'h08, 8'h09,
		8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f};
	localparam int PIN_COUNT = 5;
	localparam int CMP_COUNT = 4;

	function automatic logic [7:0] vector_addr(input logic [SRC_W-1:0] idx);
		logic [7:0] nat;
		nat = (idx < SRC_W'(SRC_COUNT)) ? NATURAL_PRIO[idx] : 8'h01;
		return 8'((nat - 8'h01) * VEC_INTERVAL + VEC_BASE);
	endfunction
endpackage

`default_nettype wire

// >>> rtl/irq_link_if.sv
// Purpose: Link between the interrupt controller and the processor core.
// Assumes: Both ends on the same clock; all signals driven from flops.
// Notes: Register port plus request, acknowledge and return strobes.
`default_nettype none

interface irq_link_if;
	import irq_pkg::*;
	logic [7:0] sfr_addr;
	logic sfr_wr;
	logic sfr_rd;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic irq_req;
	logic [SRC_W-1:0] irq_index;
	logic irq_high;
	logic irq_ack;
	logic [SRC_W-1:0] ack_index;
	logic irq_done;

	modport ctrl (
		input sfr_addr, sfr_wr, sfr_rd, sfr_wdata, irq_ack, ack_index, irq_done,
		output sfr_rdata, irq_req, irq_index, irq_high
	);
	modport core (
		output sfr_addr, sfr_wr, sfr_rd, sfr_wdata, irq_ack, ack_index, irq_done,
		input sfr_rdata, irq_req, irq_index, irq_high
	);
endinterface

`default_nettype wire

// >>> rtl/ext_irq_ctrl.sv
// Purpose: Extended interrupt flags, enables, priorities and arbitration.
// Assumes: Pins active low, from outside the clock domain.
// Notes: Unit requests and compare events are same-clock logic.
`default_nettype none

module ext_irq_ctrl (
	input wire logic CLK,
	input wire logic SRST,
	irq_link_if.ctrl LINK,
	input wire logic [irq_pkg::PIN_COUNT-1:0] EXT_PIN_IRQ_N,
	input wire logic WAKEUP_GATE_N,
	input wire logic [7:0] COMPARE_CAPTURE_ENABLE,
	input wire logic [irq_pkg::CMP_COUNT-1:0] COMPARE_EVENT,
	input wire logic TIMER1_OVERFLOW,
	input wire logic SERIAL0_RX_DONE,
	input wire logic SERIAL0_TX_DONE,
	input wire logic SERIAL1_RX_DONE,
	input wire logic SERIAL1_TX_DONE,
	input wire logic WATCHDOG_REQ,
	input wire logic I2C_MASTER_REQ,
	input wire logic I2C_SLAVE_REQ,
	input wire logic SPI_REQ,
	output logic [7:0] SERIAL0_CTRL,
	output logic [7:0] SERIAL1_CTRL
);
	import irq_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [PIN_COUNT-1:0] pin_meta;
		logic [PIN_COUNT-1:0] pin_sync;
		logic [7:0] flags;
		logic [7:0] serial0;
		logic [7:0] serial1;
		logic [7:0] enables;
		logic [7:0] prios;
		logic [7:0] base_en;
		logic [7:0] base_pri;
		logic [7:0] dev_ctrl;
		logic t1_flag;
		logic in_hi;
		logic in_lo;
		logic req;
		logic [SRC_W-1:0] index;
		logic high;
		logic [7:0] rdata;
	} ctl_state_type;

	ctl_state_type state_r;
	ctl_state_type state_nxt;

	logic [PIN_COUNT-1:0] pin_low;
	logic key_pin_low;
	logic [CMP_COUNT-1:0] cmp_mode;
	logic [7:0] clr;
	logic [SRC_COUNT-1:0] src_flag;
	logic [SRC_COUNT-1:0] src_en;
	logic [SRC_COUNT-1:0] src_pri;
	logic [SRC_COUNT-1:0] pend;
	logic found_hi;
	logic found_lo;
	logic [SRC_W-1:0] sel_hi;
	logic [SRC_W-1:0] sel_lo;
	logic ack_high;

	// ----------------------------------------
	// Source vectors in natural order
	// ----------------------------------------
	always_comb begin
		src_flag = {state_r.flags[7:6], WATCHDOG_REQ, state_r.flags[4:0],
			state_r.serial1[TX_BIT] | state_r.serial1[RX_BIT],
			state_r.serial0[TX_BIT] | state_r.serial0[RX_BIT], state_r.t1_flag};
		// Extended sources all share one enable/priority layout
		src_en = {state_r.enables, state_r.dev_ctrl[SER1_EN_BIT],
			state_r.base_en[SER0_EN_BIT], state_r.base_en[T1_EN_BIT]};
		src_pri = {state_r.prios, state_r.dev_ctrl[SER1_PRI_BIT],
			state_r.base_pri[SER0_EN_BIT], state_r.base_pri[T1_EN_BIT]};
		pend = src_flag & src_en & {SRC_COUNT{state_r.base_en[GLOBAL_EN_BIT]}};
	end

	// ----------------------------------------
	// Arbitration
	// ----------------------------------------
	always_comb begin
		found_hi = 1'b0;
		found_lo = 1'b0;
		sel_hi = '0;
		sel_lo = '0;
		// Walk downward so the lowest natural index is left standing
		for (int i = SRC_COUNT - 1; i >= 0; i--) begin
			if (pend[i] && src_pri[i]) begin
				found_hi = 1'b1;
				sel_hi = SRC_W'(i);
			end
			if (pend[i] && !src_pri[i]) begin
				found_lo = 1'b1;
				sel_lo = SRC_W'(i);
			end
		end
		ack_high = src_pri[LINK.ack_index];
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		state_nxt.pin_meta = EXT_PIN_IRQ_N;
		state_nxt.pin_sync = state_r.pin_meta;
		pin_low = ~state_r.pin_sync;
		key_pin_low = ~(WAKEUP_GATE_N | state_r.pin_sync[4]);
		for (int k = 0; k < CMP_COUNT; k++) begin
			cmp_mode[k] = COMPARE_CAPTURE_ENABLE[2*k +: 2] == CC_COMPARE_MODE;
		end
		clr = (LINK.sfr_wr && LINK.sfr_addr == EXT_FLAGS_ADDR) ? LINK.sfr_wdata : REG_RESET;

		// Flag byte: writes only ever clear, and a set in the same cycle wins
		state_nxt.flags[0] = pin_low[0];
		state_nxt.flags[1] = cmp_mode[0] ? (COMPARE_EVENT[0] | (state_r.flags[1] & ~clr[1]))
			: pin_low[1];
		state_nxt.flags[2] = cmp_mode[1] ? (COMPARE_EVENT[1] | (state_r.flags[2] & ~clr[2]))
			: pin_low[2];
		state_nxt.flags[3] = (cmp_mode[2] ? COMPARE_EVENT[2] : pin_low[3])
			| (state_r.flags[3] & ~clr[3]);
		state_nxt.flags[4] = (cmp_mode[3] ? COMPARE_EVENT[3] : key_pin_low)
			| (state_r.flags[4] & ~clr[4]);
		state_nxt.flags[RESERVED_FLAG_BIT] = 1'b0;
		state_nxt.flags[6] = I2C_MASTER_REQ | (state_r.flags[6] & ~clr[6]);
		state_nxt.flags[7] = I2C_SLAVE_REQ | SPI_REQ | (state_r.flags[7] & ~clr[7]);

		if (LINK.sfr_wr) begin
			unique case (LINK.sfr_addr)
				TIMER_CTRL_ADDR: state_nxt.t1_flag = LINK.sfr_wdata[T1_FLAG_BIT];
				SERIAL0_ADDR: state_nxt.serial0 = LINK.sfr_wdata;
				SERIAL1_ADDR: state_nxt.serial1 = LINK.sfr_wdata;
				BASE_EN_ADDR: state_nxt.base_en = LINK.sfr_wdata;
				BASE_PRI_ADDR: state_nxt.base_pri = LINK.sfr_wdata;
				DEV_CTRL_ADDR: state_nxt.dev_ctrl = LINK.sfr_wdata;
				EXT_EN_ADDR: state_nxt.enables = LINK.sfr_wdata;
				EXT_PRI_ADDR: state_nxt.prios = LINK.sfr_wdata;
				default: ;
			endcase
		end

		// Vectoring clears the timer flag; a fresh overflow still wins
		if (LINK.irq_ack && LINK.ack_index == SRC_TIMER1) begin
			state_nxt.t1_flag = 1'b0;
		end
		state_nxt.t1_flag = state_nxt.t1_flag | TIMER1_OVERFLOW;
		state_nxt.serial0[RX_BIT] = state_nxt.serial0[RX_BIT] | SERIAL0_RX_DONE;
		state_nxt.serial0[TX_BIT] = state_nxt.serial0[TX_BIT] | SERIAL0_TX_DONE;
		state_nxt.serial1[RX_BIT] = state_nxt.serial1[RX_BIT] | SERIAL1_RX_DONE;
		state_nxt.serial1[TX_BIT] = state_nxt.serial1[TX_BIT] | SERIAL1_TX_DONE;

		// In-service levels: return retires the highest active one first
		if (LINK.irq_done) begin
			if (state_r.in_hi) begin
				state_nxt.in_hi = 1'b0;
			end else begin
				state_nxt.in_lo = 1'b0;
			end
		end
		if (LINK.irq_ack) begin
			if (ack_high) begin
				state_nxt.in_hi = 1'b1;
			end else begin
				state_nxt.in_lo = 1'b1;
			end
		end

		// Request drops for the cycle after an acknowledge to avoid a double take
		state_nxt.req = 1'b0;
		state_nxt.high = 1'b0;
		state_nxt.index = '0;
		if (!LINK.irq_ack && found_hi && !state_r.in_hi) begin
			state_nxt.req = 1'b1;
			state_nxt.high = 1'b1;
			state_nxt.index = sel_hi;
		end else if (!LINK.irq_ack && found_lo && !state_r.in_hi && !state_r.in_lo) begin
			state_nxt.req = 1'b1;
			state_nxt.index = sel_lo;
		end

		state_nxt.rdata = REG_RESET;
		if (LINK.sfr_rd) begin
			unique case (LINK.sfr_addr)
				TIMER_CTRL_ADDR: state_nxt.rdata = {state_r.t1_flag, 7'h00};
				EXT_FLAGS_ADDR: state_nxt.rdata = state_r.flags;
				SERIAL0_ADDR: state_nxt.rdata = state_r.serial0;
				SERIAL1_ADDR: state_nxt.rdata = state_r.serial1;
				BASE_EN_ADDR: state_nxt.rdata = state_r.base_en;
				BASE_PRI_ADDR: state_nxt.rdata = state_r.base_pri;
				DEV_CTRL_ADDR: state_nxt.rdata = state_r.dev_ctrl;
				EXT_EN_ADDR: state_nxt.rdata = state_r.enables;
				EXT_PRI_ADDR: state_nxt.rdata = state_r.prios;
				default: state_nxt.rdata = REG_RESET;
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (SRST) begin
			// Pin stages reset to the idle (high) level
			state_r <= '0;
			state_r.pin_meta <= '1;
			state_r.pin_sync <= '1;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign LINK.sfr_rdata = state_r.rdata;
	assign LINK.irq_req = state_r.req;
	assign LINK.irq_index = state_r.index;
	assign LINK.irq_high = state_r.high;
	assign SERIAL0_CTRL = state_r.serial0;
	assign SERIAL1_CTRL = state_r.serial1;
endmodule

`default_nettype wire

// >>> rtl/irq_core_end.sv
// Purpose: Processor-core end: register access and interrupt vectoring.
// Assumes: User strobes are one-cycle pulses on the same clock.
// Notes: Write wins over read when both strobe together.
`default_nettype none

module irq_core_end (
	input wire logic CLK,
	input wire logic SRST,
	irq_link_if.core LINK,
	input wire logic CMD_WR,
	input wire logic CMD_RD,
	input wire logic [7:0] CMD_ADDR,
	input wire logic [7:0] CMD_WDATA,
	input wire logic RETURN_DONE,
	output logic [7:0] RD_DATA,
	output logic RD_VALID,
	output logic VECTOR_TAKEN,
	output logic [7:0] VECTOR_ADDR,
	output logic VECTOR_HIGH
);
	import irq_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
		logic rd_wait;
		logic [7:0] rd_data;
		logic rd_valid;
		logic ack;
		logic [SRC_W-1:0] ack_index;
		logic done;
		logic taken;
		logic [7:0] vaddr;
		logic vhigh;
	} core_state_type;

	core_state_type state_r;
	core_state_type state_nxt;

	always_comb begin
		state_nxt = state_r;
		state_nxt.wr = CMD_WR;
		state_nxt.rd = CMD_RD && !CMD_WR;
		if (CMD_WR || CMD_RD) begin
			state_nxt.addr = CMD_ADDR;
			state_nxt.wdata = CMD_WDATA;
		end
		// Read answer lands one cycle after the strobe reaches the far end
		state_nxt.rd_wait = state_r.rd;
		state_nxt.rd_valid = state_r.rd_wait;
		if (state_r.rd_wait) begin
			state_nxt.rd_data = LINK.sfr_rdata;
		end
		// Far end drops its request only a cycle after an acknowledge, so a second ack is blocked here
		state_nxt.ack = LINK.irq_req && !state_r.ack;
		state_nxt.taken = state_nxt.ack;
		if (state_nxt.ack) begin
			state_nxt.ack_index = LINK.irq_index;
			state_nxt.vaddr = vector_addr(LINK.irq_index);
			state_nxt.vhigh = LINK.irq_high;
		end
		state_nxt.done = RETURN_DONE;
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign LINK.sfr_addr = state_r.addr;
	assign LINK.sfr_wr = state_r.wr;
	assign LINK.sfr_rd = state_r.rd;
	assign LINK.sfr_wdata = state_r.wdata;
	assign LINK.irq_ack = state_r.ack;
	assign LINK.ack_index = state_r.ack_index;
	assign LINK.irq_done = state_r.done;
	assign RD_DATA = state_r.rd_data;
	assign RD_VALID = state_r.rd_valid;
	assign VECTOR_TAKEN = state_r.taken;
	assign VECTOR_ADDR = state_r.vaddr;
	assign VECTOR_HIGH = state_r.vhigh;
endmodule

`default_nettype wire

// >>> sim/irq_link_props.sv
// Purpose: Concurrent checks on the link between the controller and core end.
// Assumes: One clock domain; register shadows follow writes seen on the link.
// Notes: Requests come from flops, so a one-cycle-old shadow is also accepted.
`default_nettype none

module irq_link_props (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic irq_req,
	input wire logic [irq_pkg::SRC_W-1:0] irq_index,
	input wire logic irq_high,
	input wire logic irq_ack,
	input wire logic [irq_pkg::SRC_W-1:0] ack_index,
	input wire logic irq_done
);
	import irq_pkg::*;
	// ----------------------------------------
	// Shadow state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] en;
		logic [7:0] en_d;
		logic [7:0] pri;
		logic [7:0] pri_d;
		logic glob;
		logic glob_d;
		logic lvl_d;
		logic ins_hi;
		logic ins_lo;
	} shadow_type;
	shadow_type s_r;
	shadow_type s_nxt;
	logic [2:0] k;
	logic ext_src;
	assign k = 3'(irq_index - SRC_W'(3));
	assign ext_src = irq_index >= SRC_W'(3) && irq_index <= SRC_W'(10);

	always_comb begin
		s_nxt = s_r;
		s_nxt.en_d = s_r.en;
		s_nxt.pri_d = s_r.pri;
		s_nxt.glob_d = s_r.glob;
		s_nxt.lvl_d = irq_high;
		if (sfr_wr && sfr_addr == EXT_EN_ADDR) begin
			s_nxt.en = sfr_wdata;
		end
		if (sfr_wr && sfr_addr == EXT_PRI_ADDR) begin
			s_nxt.pri = sfr_wdata;
		end
		if (sfr_wr && sfr_addr == BASE_EN_ADDR) begin
			s_nxt.glob = sfr_wdata[GLOBAL_EN_BIT];
		end
		// High level retires first, as the core returns from the inner routine
		if (irq_ack) begin
			if (s_r.lvl_d) begin
				s_nxt.ins_hi = 1'b1;
			end else begin
				s_nxt.ins_lo = 1'b1;
			end
		end else if (irq_done) begin
			if (s_r.ins_hi) begin
				s_nxt.ins_hi = 1'b0;
			end else begin
				s_nxt.ins_lo = 1'b0;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);

	chk_reset_quiet: assert property ($past(SRST) |-> !irq_req && sfr_rdata == 8'h00)
		else $error("request or read data active right after reset");
	chk_reserved_zero: assert property (
		sfr_rd && sfr_addr == EXT_FLAGS_ADDR |=> !sfr_rdata[RESERVED_FLAG_BIT])
		else $error("reserved flag bit read as one");
	chk_global_gate: assert property (irq_req |-> s_r.glob || s_r.glob_d)
		else $error("request raised with global enable off");
	chk_enable_gate: assert property (irq_req && ext_src |-> s_r.en[k] || s_r.en_d[k])
		else $error("request raised for a disabled source");
	chk_shared_gate: assert property (
		irq_req && irq_index == SRC_W'(10) |-> s_r.en[7] || s_r.en_d[7])
		else $error("shared slave or spi request without its enable");
	chk_prio_level: assert property (
		irq_req && ext_src |-> irq_high == s_r.pri[k] || irq_high == s_r.pri_d[k])
		else $error("request level differs from its priority bit");
	chk_ack_drop: assert property (irq_ack |=> !irq_req)
		else $error("request held after acknowledge");
	chk_low_nesting: assert property (
		irq_req && !irq_high |-> !s_r.ins_hi && !s_r.ins_lo)
		else $error("low request while a routine is in service");
	chk_high_nesting: assert property (irq_req && irq_high |-> !s_r.ins_hi)
		else $error("high request while high routine in service");
	chk_ack_cause: assert property (
		irq_ack |-> $past(irq_req) && ack_index == $past(irq_index))
		else $error("acknowledge without matching request");
endmodule

`default_nettype wire

// >>> sim/extended_interrupt_control_test.sv
// Purpose: Self-checking bench for the controller and core end pair.
// Assumes: Pins idle high; inputs change on the falling clock edge.
// Notes: Vector addresses expected from natural order, interval eight.
`default_nettype none

module extended_interrupt_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	import irq_pkg::*;
	logic clk, srst, cmd_wr, cmd_rd, ret_done, gate_n, wd_req, rd_valid, vec_taken, vec_high;
	logic [7:0] cmd_addr, cmd_wdata, cc_enable, rd_data, vec_addr, s0_ctrl, s1_ctrl, ev;
	logic [4:0] pins_n;
	logic [3:0] cmp_ev;
	int num_errors, checks, i;
	logic [7:0] regs [6] = '{EXT_FLAGS_ADDR, SERIAL0_ADDR, SERIAL1_ADDR, EXT_EN_ADDR,
		EXT_PRI_ADDR, 8'h55};
	logic [7:0] ev_mask [3] = '{8'h20, 8'h40, 8'h80};
	logic [7:0] ev_flag [3] = '{8'h40, 8'h80, 8'h80};

	// ----------------------------------------
	// Design and checker
	// ----------------------------------------
	irq_link_if link();
	ext_irq_ctrl ext_irq_ctrl_inst(.CLK(clk), .SRST(srst), .LINK(link), .EXT_PIN_IRQ_N(pins_n),
		.WAKEUP_GATE_N(gate_n), .COMPARE_CAPTURE_ENABLE(cc_enable), .COMPARE_EVENT(cmp_ev),
		.TIMER1_OVERFLOW(ev[0]), .SERIAL0_RX_DONE(ev[1]), .SERIAL0_TX_DONE(ev[2]),
		.SERIAL1_RX_DONE(ev[3]), .SERIAL1_TX_DONE(ev[4]), .WATCHDOG_REQ(wd_req),
		.I2C_MASTER_REQ(ev[5]), .I2C_SLAVE_REQ(ev[6]), .SPI_REQ(ev[7]),
		.SERIAL0_CTRL(s0_ctrl), .SERIAL1_CTRL(s1_ctrl));
	irq_core_end irq_core_end_inst(.CLK(clk), .SRST(srst), .LINK(link), .CMD_WR(cmd_wr),
		.CMD_RD(cmd_rd), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .RETURN_DONE(ret_done),
		.RD_DATA(rd_data), .RD_VALID(rd_valid), .VECTOR_TAKEN(vec_taken),
		.VECTOR_ADDR(vec_addr), .VECTOR_HIGH(vec_high));
	irq_link_props irq_link_props_inst(.CLK(clk), .SRST(srst), .sfr_addr(link.sfr_addr),
		.sfr_wr(link.sfr_wr), .sfr_rd(link.sfr_rd), .sfr_wdata(link.sfr_wdata),
		.sfr_rdata(link.sfr_rdata), .irq_req(link.irq_req), .irq_index(link.irq_index),
		.irq_high(link.irq_high), .irq_ack(link.irq_ack), .ack_index(link.ack_index),
		.irq_done(link.irq_done));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		cmd_wr = 1'b1;
		cmd_addr = a;
		cmd_wdata = d;
		@(negedge clk);
		cmd_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		int n;
		@(negedge clk);
		cmd_rd = 1'b1;
		cmd_addr = a;
		@(negedge clk);
		cmd_rd = 1'b0;
		for (n = 0; n < 8 && rd_valid !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (rd_valid !== 1'b1) begin
			num_errors++;
			stop_test();
		end
		check(rd_data, exp);
	endtask

	task automatic wait_vec(input logic [7:0] a, input logic h);
		int n;
		for (n = 0; n < 20 && vec_taken !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (vec_taken !== 1'b1) begin
			num_errors++;
			stop_test();
		end
		check(vec_addr, a);
		check({7'h00, vec_high}, {7'h00, h});
	endtask

	task automatic no_vec(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
			check({7'h00, vec_taken}, 8'h00);
		end
	endtask

	// One-cycle pulses on the event inputs and the return strobe
	task automatic pulse(input logic [7:0] m, input logic [3:0] c, input logic r);
		@(negedge clk);
		ev = m;
		cmp_ev = c;
		ret_done = r;
		@(negedge clk);
		ev = 8'h00;
		cmp_ev = 4'h0;
		ret_done = 1'b0;
	endtask

	// Waits out the two-stage pin synchroniser
	task automatic set_pins(input logic [4:0] p, input logic g);
		@(negedge clk);
		pins_n = p;
		gate_n = g;
		repeat (4) @(negedge clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{srst, pins_n, gate_n} = 7'h7f;
		{cmd_wr, cmd_rd, ret_done, wd_req} = 4'h0;
		{cmd_addr, cmd_wdata, cc_enable, ev, cmp_ev} = 36'h0;
		num_errors = 0;
		checks = 0;
		repeat (3) @(negedge clk);
		srst = 1'b0;
		foreach (regs[j]) begin
			rd(regs[j], 8'h00);
		end
		wr(EXT_EN_ADDR, 8'ha5);
		rd(EXT_EN_ADDR, 8'ha5);
		wr(EXT_PRI_ADDR, 8'h5a);
		rd(EXT_PRI_ADDR, 8'h5a);
		wr(EXT_EN_ADDR, 8'h00);
		wr(EXT_PRI_ADDR, 8'h00);
		set_pins(5'h1e, 1'b1);
		rd(EXT_FLAGS_ADDR, 8'h01);
		wr(EXT_FLAGS_ADDR, 8'h01);
		rd(EXT_FLAGS_ADDR, 8'h01);
		set_pins(5'h1f, 1'b1);
		wr(EXT_FLAGS_ADDR, 8'hff);
		rd(EXT_FLAGS_ADDR, 8'h00);
		set_pins(5'h07, 1'b1);
		rd(EXT_FLAGS_ADDR, 8'h08);
		set_pins(5'h07, 1'b0);
		rd(EXT_FLAGS_ADDR, 8'h18);
		set_pins(5'h1f, 1'b1);
		wr(EXT_FLAGS_ADDR, 8'h08);
		rd(EXT_FLAGS_ADDR, 8'h10);
		wr(EXT_FLAGS_ADDR, 8'h10);
		rd(EXT_FLAGS_ADDR, 8'h00);
		@(negedge clk);
		cc_enable = 8'haa;
		pulse(8'h00, 4'hf, 1'b0);
		rd(EXT_FLAGS_ADDR, 8'h1e);
		for (i = 0; i < 4; i++) begin
			wr(EXT_FLAGS_ADDR, 8'(8'h02 << i));
			rd(EXT_FLAGS_ADDR, 8'(8'h1e & (8'hfc << i)));
		end
		foreach (ev_mask[j]) begin
			pulse(ev_mask[j], 4'h0, 1'b0);
			rd(EXT_FLAGS_ADDR, ev_flag[j]);
			wr(EXT_FLAGS_ADDR, ev_flag[j]);
			rd(EXT_FLAGS_ADDR, 8'h00);
		end
		pulse(8'h1e, 4'h0, 1'b0);
		rd(SERIAL1_ADDR, 8'h03);
		check(s1_ctrl, 8'h03);
		rd(SERIAL0_ADDR, 8'h03);
		check(s0_ctrl, 8'h03);
		wr(SERIAL1_ADDR, 8'h00);
		wr(SERIAL0_ADDR, 8'h00);
		// Radio and key tie at low level; the lower natural number wins
		wr(EXT_EN_ADDR, 8'h98);
		wr(EXT_PRI_ADDR, 8'h80);
		pulse(8'h00, 4'hc, 1'b0);
		no_vec(6);
		wr(BASE_EN_ADDR, 8'h80);
		wait_vec(8'h53, 1'b0);
		no_vec(6);
		pulse(8'h40, 4'h0, 1'b0);
		wait_vec(8'h73, 1'b1);
		wr(EXT_FLAGS_ADDR, 8'h98);
		rd(EXT_FLAGS_ADDR, 8'h00);
		pulse(8'h00, 4'h0, 1'b1);
		pulse(8'h00, 4'h0, 1'b1);
		no_vec(6);
		wr(BASE_EN_ADDR, 8'h88);
		pulse(8'h01, 4'h0, 1'b0);
		wait_vec(8'h1b, 1'b0);
		rd(TIMER_CTRL_ADDR, 8'h00);
		pulse(8'h00, 4'h0, 1'b1);
		// Watchdog level request through its own enable bit
		wr(EXT_EN_ADDR, 8'h20);
		@(negedge clk);
		wd_req = 1'b1;
		wait_vec(8'h63, 1'b0);
		@(negedge clk);
		wd_req = 1'b0;
		pulse(8'h00, 4'h0, 1'b1);
		stop_test();
	end
endmodule

`default_nettype wire
